/* File: fcp_pkg.sv */
// Shared constants for the flash control and power register block.
// Assumes a single 20 MHz system clock and an AHB-Lite register bus.
package fcp_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] FCP_IDX_CTRL = 32'h0000_1fe0;
  localparam logic [31:0] FCP_IDX_WTIME = 32'h0000_1fe2;
  localparam logic [31:0] FCP_IDX_STATUS = 32'h0000_1fe4;
  localparam logic [31:0] FCP_ADDR_CTRL = FCP_IDX_CTRL << 2;
  localparam logic [31:0] FCP_ADDR_WTIME = FCP_IDX_WTIME << 2;
  localparam logic [31:0] FCP_ADDR_STATUS = FCP_IDX_STATUS << 2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FCP_KEY_LSB = 4;
  localparam int FCP_FSTOP_BIT = 2;
  localparam int FCP_AUTO_BIT = 1;
  localparam int FCP_MAN_BIT = 0;
  localparam int FCP_ST_WARM_BIT = 0;
  localparam int FCP_ST_BUSY_BIT = 1;
  localparam int FCP_ST_PWR_BIT = 2;
  localparam int FCP_ST_STALL_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FCP_KEY_LOCK = 4'hc;
  localparam logic [3:0] FCP_KEY_OPEN = 4'h3;
  localparam logic FCP_AUTO_RST = 1'h1;
  localparam logic FCP_MAN_RST = 1'h1;
  localparam logic [2:0] FCP_WTIME_RST = 3'h0;
  localparam logic [2:0] FCP_WTIME_MAX = 3'h4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int FCP_CLK_HZ = 20_000_000;
  localparam int FCP_WARM_FAST_EXP = 10;
  localparam int FCP_WARM_SLOW_EXP = 3;
  localparam int FCP_WR_FAST_EXP = 16;
  localparam int FCP_WR_SLOW_EXP = 7;
  localparam int FCP_FLASH_WR_MS = 4;
  localparam int FCP_FLASH_WR_CYC = FCP_FLASH_WR_MS * (FCP_CLK_HZ / 1000);
  localparam int FCP_TMR_W = 17;

  typedef enum logic [1:0] {
    FCP_VAR_FLASH = 2'b00,
    FCP_VAR_EMUL = 2'b01,
    FCP_VAR_MASKED = 2'b10
  } fcp_variant_t;

endpackage

/* File: fcp_timer.sv */
// Loadable down-counting timer with an expiry pulse.
// Assumes a synchronous reset copy and a tick enable from the same clock.
`timescale 1ns/1ns
module fcp_timer import fcp_pkg::*; #(
  parameter int W = FCP_TMR_W
) (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic tick,
  input wire logic [W-1:0] loadVal,
  // Status
  output logic running,
  output logic expire
);

  typedef struct packed {
    logic run;
    logic done;
    logic [W-1:0] cnt;
  } fcp_tmr_t;

  fcp_tmr_t st_ff;
  fcp_tmr_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (abort) begin
      nxt_st.run = 1'b0;
    end else if (start) begin
      nxt_st.run = 1'b1;
      nxt_st.cnt = loadVal;
    end else if (st_ff.run && tick) begin
      if (st_ff.cnt <= W'(1)) begin
        nxt_st.run = 1'b0;
        nxt_st.done = 1'b1;
        nxt_st.cnt = '0;
      end else begin
        nxt_st.cnt = st_ff.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign running = st_ff.run;
  assign expire = st_ff.done;

endmodule // fcp_timer

/* File: fcp_flash_ctrl.sv */
// Flash control, write-protect, forced stop, power and write-time registers.
// Assumes a CPU flag telling whether the current fetch is from RAM/boot ROM.
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ns
module fcp_flash_ctrl import fcp_pkg::*; #(
  parameter fcp_variant_t VARIANT = FCP_VAR_FLASH,
  parameter int FLASH_WR_CYC = FCP_FLASH_WR_CYC
) (
  // Clock, enable and reset
  input wire logic mclk,
  input wire logic ce,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // CPU and system state
  input wire logic fetchFromRam,
  input wire logic lowPowerMode,
  input wire logic stopMode,
  input wire logic systemClockSelect,
  input wire logic slowClockTick,
  // Flash array side
  input wire logic pageBufferWrite,
  input wire logic pageCommit,
  input wire logic [7:0] flashArrayData,
  output logic [7:0] flashReadData,
  output logic ctrlPowerOn,
  output logic writeEnabled,
  output logic writeBusy,
  output logic writeAbort,
  output logic bufCounterClear,
  output logic cpuStall
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic dpWr;
    logic dpCtrl;
    logic dpWtime;
    logic dpRam;
    logic [3:0] key;
    logic autoPd;
    logic manPw;
    logic [2:0] wtCode;
    logic pwr;
    logic warmDone;
    logic stall;
    logic swWake;
    logic busy;
    logic abort;
    logic [7:0] fdata;
    logic [31:0] rdata;
  } fcp_state_t;

  fcp_state_t st_ff;
  fcp_state_t nxt_st;
  logic [1:0] rstSync_ff;
  logic rstSync;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstSync_ff <= 2'h0;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstSync = rstSync_ff[1];

  // ----------------------------------------------------------------
  // Timing helpers
  // ----------------------------------------------------------------
  function automatic logic [FCP_TMR_W-1:0] pow2(input int e);
    pow2 = FCP_TMR_W'(1) << e;
  endfunction

  function automatic logic [FCP_TMR_W-1:0] emul_cycles(input logic [2:0] code,
                                                       input logic slow);
    logic [2:0] c;
    c = (code > FCP_WTIME_MAX) ? FCP_WTIME_MAX : code;
    emul_cycles = slow ? pow2(FCP_WR_SLOW_EXP - int'(c)) : pow2(FCP_WR_FAST_EXP - int'(c));
  endfunction

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  logic addrPhase;
  logic wrCtrl;
  logic ctrlWrOk;
  logic forcedStop;
  logic powerNow;
  logic powerRise;
  logic hwWake;
  logic warmLoad;
  logic warmExpire;
  logic warmRun;
  logic wrStart;
  logic wrExpire;
  logic wrRun;
  logic tmrTick;
  logic [FCP_TMR_W-1:0] warmLen;
  logic [FCP_TMR_W-1:0] wrLen;

  assign addrPhase = hsel && hready && htrans[1];
  assign wrCtrl = st_ff.dpWr && st_ff.dpCtrl;
  assign ctrlWrOk = wrCtrl && st_ff.dpRam;
  assign forcedStop = ctrlWrOk && hwdata[FCP_FSTOP_BIT];
  assign hwWake = (powerRise && !st_ff.swWake) || (forcedStop && st_ff.busy);
  // Manual off, stop, or auto shut-down in idle/sleep
  assign powerNow = st_ff.manPw && !stopMode && !(st_ff.autoPd && lowPowerMode);
  assign powerRise = powerNow && !st_ff.pwr;
  assign warmLoad = powerRise || (forcedStop && st_ff.busy);
  assign tmrTick = systemClockSelect ? slowClockTick : 1'b1;
  assign warmLen = systemClockSelect ? pow2(FCP_WARM_SLOW_EXP) : pow2(FCP_WARM_FAST_EXP);
  assign wrStart = pageCommit && st_ff.busy && st_ff.warmDone && !wrRun && !forcedStop;
  // Emulation part uses the code; flash part its own fixed timing
  assign wrLen = (VARIANT == FCP_VAR_EMUL) ? emul_cycles(st_ff.wtCode, systemClockSelect)
               : FCP_TMR_W'(FLASH_WR_CYC);

  fcp_timer #(.W(FCP_TMR_W)) uWarm (
    .mclk(mclk),
    .rstn(rstSync),
    .ce(ce),
    .start(warmLoad),
    .abort(!powerNow),
    .tick(tmrTick),
    .loadVal(warmLen),
    .running(warmRun),
    .expire(warmExpire)
  );

  fcp_timer #(.W(FCP_TMR_W)) uWrite (
    .mclk(mclk),
    .rstn(rstSync),
    .ce(ce),
    .start(wrStart),
    .abort(forcedStop),
    .tick((VARIANT == FCP_VAR_EMUL) ? tmrTick : 1'b1),
    .loadVal(wrLen),
    .running(wrRun),
    .expire(wrExpire)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.abort = forcedStop;
    nxt_st.pwr = powerNow;
    // Control write just landed: a power rise now is software's own
    nxt_st.swWake = wrCtrl;
    // Address phase capture
    if (addrPhase) begin
      nxt_st.dpWr = hwrite;
      nxt_st.dpCtrl = (haddr == FCP_ADDR_CTRL);
      nxt_st.dpWtime = (haddr == FCP_ADDR_WTIME);
      nxt_st.dpRam = fetchFromRam;
    end else if (hready) begin
      nxt_st.dpWr = 1'b0;
      nxt_st.dpCtrl = 1'b0;
      nxt_st.dpWtime = 1'b0;
    end
    // Read data registered at the address phase
    if (addrPhase && !hwrite) begin
      if (haddr == FCP_ADDR_CTRL) begin
        nxt_st.rdata = {24'h0, st_ff.key, 2'h0, st_ff.autoPd, st_ff.manPw};
      end else if (haddr == FCP_ADDR_WTIME) begin
        nxt_st.rdata = {29'h0, st_ff.wtCode};
      end else if (haddr == FCP_ADDR_STATUS) begin
        nxt_st.rdata = {28'h0, st_ff.stall, st_ff.pwr, st_ff.busy, st_ff.warmDone};
      end else begin
        nxt_st.rdata = 32'h0;
      end
    end
    // Register writes in the data phase
    if (ctrlWrOk) begin
      nxt_st.key = hwdata[FCP_KEY_LSB +: 4];
      nxt_st.manPw = hwdata[FCP_MAN_BIT];
    end
    if (wrCtrl) begin
      nxt_st.autoPd = hwdata[FCP_AUTO_BIT];
    end
    if (st_ff.dpWr && st_ff.dpWtime) begin
      nxt_st.wtCode = hwdata[2:0];
    end
    // Warm-up status
    if (!powerNow || warmLoad) begin
      nxt_st.warmDone = 1'b0;
    end else if (warmExpire) begin
      nxt_st.warmDone = 1'b1;
    end
    // CPU wait when hardware starts the warm-up itself or a forced stop hits a busy write
    if (hwWake) begin
      nxt_st.stall = 1'b1;
    end else if (warmExpire || !powerNow) begin
      nxt_st.stall = 1'b0;
    end
    // Page buffer busy
    if (forcedStop && !st_ff.busy) begin
      nxt_st.busy = 1'b0;
    end else if (st_ff.stall && warmExpire) begin
      nxt_st.busy = 1'b0;
    end else if (pageBufferWrite && !st_ff.busy && !forcedStop && st_ff.warmDone &&
                 st_ff.key == FCP_KEY_OPEN && VARIANT != FCP_VAR_MASKED) begin
      nxt_st.busy = 1'b1;
    end else if (wrExpire) begin
      nxt_st.busy = 1'b0;
    end
    nxt_st.fdata = st_ff.warmDone ? flashArrayData : 8'hff;
  end

  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      st_ff <= '{dpWr: 1'b0, dpCtrl: 1'b0, dpWtime: 1'b0, dpRam: 1'b0,
                 key: FCP_KEY_LOCK, autoPd: FCP_AUTO_RST, manPw: FCP_MAN_RST,
                 wtCode: FCP_WTIME_RST, pwr: 1'b0, warmDone: 1'b0, stall: 1'b0,
                 busy: 1'b0, abort: 1'b0, swWake: 1'b0, fdata: 8'hff, rdata: 32'h0};
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_ff.rdata;
  assign flashReadData = st_ff.fdata;
  assign ctrlPowerOn = st_ff.pwr;
  assign writeEnabled = (st_ff.key == FCP_KEY_OPEN) && (VARIANT != FCP_VAR_MASKED);
  assign writeBusy = st_ff.busy;
  assign writeAbort = st_ff.abort;
  assign bufCounterClear = st_ff.abort;
  assign cpuStall = st_ff.stall;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstSync || !ce);

  a_ctrl_read_bits: assert property (addrPhase && !hwrite && haddr == FCP_ADDR_CTRL
    |=> hrdata[3:2] == 2'h0) else $error("control read bits 3:2 not zero");
  a_flash_fetch_block: assert property (wrCtrl && !st_ff.dpRam
    |=> st_ff.key == $past(st_ff.key) && st_ff.manPw == $past(st_ff.manPw))
    else $error("control written from flash fetch");
  a_key_write: assert property (ctrlWrOk |=> st_ff.key == $past(hwdata[7:4]))
    else $error("key not loaded");
  a_force_abort: assert property (forcedStop |=> writeAbort && bufCounterClear && !wrRun)
    else $error("forced stop did not abort");
  a_auto_down: assert property (st_ff.autoPd && lowPowerMode |=> !ctrlPowerOn)
    else $error("auto power down ignored");
  a_manual_off: assert property (!st_ff.manPw |=> !ctrlPowerOn)
    else $error("power on with manual bit clear");
  a_stop_off: assert property (stopMode |=> !ctrlPowerOn)
    else $error("power on in stop mode");
  a_warm_fast: assert property (powerRise && !systemClockSelect && !lowPowerMode &&
    !stopMode ##1 (powerNow && !warmLoad)[*8] |-> !st_ff.warmDone)
    else $error("warm-up ended early");
  a_ff_mask: assert property (!st_ff.warmDone |=> flashReadData == 8'hff)
    else $error("flash data before warm-up");
  a_wtime_read: assert property (addrPhase && !hwrite && haddr == FCP_ADDR_WTIME
    |=> hrdata[31:3] == 29'h0 && hrdata[2:0] == $past(st_ff.wtCode))
    else $error("write-time read wrong");
  a_sw_wake: assert property (powerRise && st_ff.swWake && !forcedStop |=> !cpuStall)
    else $error("CPU held after software power-up");
  a_busy_stop_wait: assert property (forcedStop && st_ff.busy
    |=> cpuStall && !st_ff.warmDone) else $error("forced stop skipped warm-up");

  c_forced_busy: cover property (forcedStop && st_ff.busy);
  c_warm_done: cover property ($rose(st_ff.warmDone));
  c_write_done: cover property (wrExpire);
  c_sw_wake: cover property (powerRise && st_ff.swWake);

endmodule // fcp_flash_ctrl

/* File: fcp_cpu_model.sv */
// Partner model of the CPU side: fetch area flag, slow ticks, array bytes.
// Assumes the bench says where code runs; all outputs change after mclk rises.
`timescale 1ns/1ns
module fcp_cpu_model (
  // Clock
  input wire logic mclk,
  // From bench
  input wire logic execRam,
  // To block
  output logic fetchFromRam,
  output logic slowClockTick,
  output logic [7:0] flashArrayData
);
  logic [3:0] divCnt = 4'h0;
  initial slowClockTick = 1'b0;
  initial flashArrayData = 8'h11;
  // Writes to protected bits only count from RAM/boot fetch
  assign fetchFromRam = execRam;
  // Slow tick every 16 cycles; array byte changes every cycle
  always @(posedge mclk) begin
    divCnt <= divCnt + 4'h1;
    slowClockTick <= (divCnt == 4'hf);
    flashArrayData <= flashArrayData * 8'h05 + 8'h3b;
  end
endmodule // fcp_cpu_model

/* File: flash_control_power_regs_tb.sv */
// Self-checking bench for the flash control and power register block.
// Assumes flash variant with short page write, an emulation shadow, zero wait bus.
`timescale 1ns/1ns
module flash_control_power_regs_tb;
  import fcp_pkg::*;
  localparam int WR_CYC = 64;
  localparam int EMU_CYC = 1 << (FCP_WR_FAST_EXP - int'(FCP_WTIME_MAX));
  logic ce = 1'b1;
  logic emuBusy;
  int m;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, fetchFromRam, slowClockTick;
  logic [31:0] hrdata;
  logic execRam = 1'b1;
  logic lowPowerMode = 1'b0;
  logic stopMode = 1'b0;
  logic systemClockSelect = 1'b0;
  logic pageBufferWrite = 1'b0;
  logic pageCommit = 1'b0;
  logic rdPh = 1'b0;
  logic [7:0] flashArrayData, flashReadData;
  logic ctrlPowerOn, writeEnabled, writeBusy, writeAbort, bufCounterClear, cpuStall;
  logic [31:0] seed = 32'hdb4a;
  logic [31:0] expQ[$];
  int err_count = 0;
  int compares = 0;
  int abortCnt = 0;
  int n;
  logic [31:0] d;

  fcp_flash_ctrl #(.VARIANT(FCP_VAR_FLASH), .FLASH_WR_CYC(WR_CYC)) u_dut (
    .mclk(mclk), .ce(ce), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fetchFromRam(fetchFromRam),
    .lowPowerMode(lowPowerMode), .stopMode(stopMode), .systemClockSelect(systemClockSelect),
    .slowClockTick(slowClockTick), .pageBufferWrite(pageBufferWrite),
    .pageCommit(pageCommit), .flashArrayData(flashArrayData),
    .flashReadData(flashReadData), .ctrlPowerOn(ctrlPowerOn), .writeEnabled(writeEnabled),
    .writeBusy(writeBusy), .writeAbort(writeAbort), .bufCounterClear(bufCounterClear),
    .cpuStall(cpuStall));

  fcp_cpu_model u_cpu (.mclk(mclk), .execRam(execRam), .fetchFromRam(fetchFromRam),
    .slowClockTick(slowClockTick), .flashArrayData(flashArrayData));

  // Emulation shadow on the same inputs; only its page write timing is watched
  fcp_flash_ctrl #(.VARIANT(FCP_VAR_EMUL)) u_emu (
    .mclk(mclk), .ce(ce), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(), .hresp(), .hrdata(), .fetchFromRam(fetchFromRam),
    .lowPowerMode(lowPowerMode), .stopMode(stopMode), .systemClockSelect(systemClockSelect),
    .slowClockTick(slowClockTick), .pageBufferWrite(pageBufferWrite),
    .pageCommit(pageCommit), .flashArrayData(flashArrayData),
    .flashReadData(), .ctrlPowerOn(), .writeEnabled(), .writeBusy(emuBusy),
    .writeAbort(), .bufCounterClear(), .cpuStall());

  initial begin
    forever #25 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] dat);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= dat;
    rdPh <= !w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdPh <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask

  // Cycles until stall (sel 0) or busy (sel 1) drops
  task automatic waitLow(input logic sel, output int cnt);
    cnt = 0;
    while ((sel ? writeBusy : cpuStall) !== 1'b0 && cnt < 3000) begin
      @(posedge mclk);
      #1 cnt++;
    end
  endtask

  task automatic pulse(input logic commit);
    @(posedge mclk);
    if (commit) pageCommit <= 1'b1;
    else pageBufferWrite <= 1'b1;
    @(posedge mclk);
    pageCommit <= 1'b0;
    pageBufferWrite <= 1'b0;
  endtask

  task automatic powerIs(input logic e);
    repeat (3) @(posedge mclk);
    #1 chk(ctrlPowerOn, e);
  endtask

  // Read results are taken off the bus and abort pulses are counted as they appear
  always @(posedge mclk) begin
    if (rdPh) begin
      chk(hrdata, expQ.pop_front());
      chk(hresp, 1'b0);
    end
    if (writeAbort && bufCounterClear) abortCnt++;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (10) @(posedge mclk);
    #1 chk(cpuStall, 1'b1);
    waitLow(1'b0, n);
    chk(32'(n inside {[1000:1030]}), 32'h1);
    rd(FCP_ADDR_CTRL, 32'hc3);
    rd(FCP_ADDR_WTIME, 32'h0);
    rd(FCP_ADDR_STATUS, 32'h5);
    rd(32'h10, 32'h0);
    @(posedge mclk);
    d = 32'(flashArrayData);
    #1 chk(32'(flashReadData), d);
    execRam <= 1'b0;
    bus(FCP_ADDR_CTRL, 1'b1, 32'h3c);
    rd(FCP_ADDR_CTRL, 32'hc1);
    chk(abortCnt, 0);
    chk(writeEnabled, 1'b0);
    execRam <= 1'b1;
    bus(FCP_ADDR_CTRL, 1'b1, 32'h37);
    rd(FCP_ADDR_CTRL, 32'h33);
    chk(abortCnt, 1);
    chk(writeEnabled, 1'b1);
    chk(cpuStall, 1'b0);
    for (int i = 0; i < 6; i++) begin
      d = rnd();
      bus(FCP_ADDR_WTIME, 1'b1, d);
      rd(FCP_ADDR_WTIME, {29'h0, d[2:0]});
    end
    bus(FCP_ADDR_WTIME, 1'b1, 32'(FCP_WTIME_MAX));
    pulse(1'b0);
    #1 chk(writeBusy, 1'b1);
    pulse(1'b1);
    waitLow(1'b1, n);
    chk(32'(n inside {[WR_CYC-4:WR_CYC+4]}), 32'h1);
    m = n;
    while (emuBusy !== 1'b0 && m < 6000) begin
      @(posedge mclk);
      #1 m++;
    end
    chk(32'(m inside {[EMU_CYC-4:EMU_CYC+4]}), 32'h1);
    pulse(1'b0);
    bus(FCP_ADDR_CTRL, 1'b1, 32'h37);
    repeat (3) @(posedge mclk);
    #1 chk(cpuStall, 1'b1);
    chk(abortCnt, 2);
    waitLow(1'b0, n);
    chk(32'(n inside {[1000:1030]}), 32'h1);
    chk(writeBusy, 1'b0);
    bus(FCP_ADDR_CTRL, 1'b1, 32'h32);
    powerIs(1'b0);
    chk(32'(flashReadData), 32'hff);
    lowPowerMode <= 1'b1;
    bus(FCP_ADDR_CTRL, 1'b1, 32'h33);
    powerIs(1'b0);
    bus(FCP_ADDR_CTRL, 1'b1, 32'h31);
    powerIs(1'b1);
    repeat (900) @(posedge mclk);
    rd(FCP_ADDR_STATUS, 32'h4);
    repeat (200) @(posedge mclk);
    rd(FCP_ADDR_STATUS, 32'h5);
    lowPowerMode <= 1'b0;
    systemClockSelect <= 1'b1;
    bus(FCP_ADDR_CTRL, 1'b1, 32'h30);
    powerIs(1'b0);
    bus(FCP_ADDR_CTRL, 1'b1, 32'h31);
    repeat (95) @(posedge mclk);
    rd(FCP_ADDR_STATUS, 32'h4);
    repeat (60) @(posedge mclk);
    rd(FCP_ADDR_STATUS, 32'h5);
    systemClockSelect <= 1'b0;
    stopMode <= 1'b1;
    powerIs(1'b0);
    stopMode <= 1'b0;
    powerIs(1'b1);
    ce <= 1'b0;
    stopMode <= 1'b1;
    powerIs(1'b1);
    ce <= 1'b1;
    powerIs(1'b0);
    stopMode <= 1'b0;
    bus(FCP_ADDR_CTRL, 1'b1, 32'h30);
    stopMode <= 1'b1;
    powerIs(1'b0);
    stopMode <= 1'b0;
    powerIs(1'b0);
    repeat (4) @(posedge mclk);
    wrap_up();
  end
endmodule // flash_control_power_regs_tb
